// ---- logic/dbc_top.v ----
// Dual 8-bit down counter with cascade, frame counting and capture, APB slave
//
// Overview of operation
// - Two identical byte counters share one clock source, own period and compare.
// - Each counter decrements per selected clock, reloads from top after zero.
// - Zero is bottom; all ones is maximum.
// - Configurations: two byte, wide, byte plus frame, two frame, byte plus two nibble counters.
// - Cascaded mode joins both into one 16-bit counter with 16-bit registers.
// - Update pulse at bottom or top, chosen by waveform mode.
// - Clear request from peripheral, event system or software forces zero next.
// - Top equals period or compare setting, chosen by waveform mode.
// - Four-bit selection routes a prescaler output or an event channel.
// - After reset no clock is selected; counters stay stopped.
// - Software count write is immediate and beats count, clear and reload.
// - Period writes affect only the next reload, not the running period.
// - Capture mode reloads all ones at bottom; period register holds captures.
// - Selected channel captures first counter; next channel captures second.
// - Capture copies present count into the period/capture register.
// - Input capture stores count and sets the capture flag.
// - Frequency capture on rising edge captures and restarts the counter.
// - Pulse-width action restarts on rising edge, captures on falling edge.
// - Software restart of a byte counter loads top value (all ones in capture mode) and zeroes compare outputs.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dbc_map.vh"
module dbc_top #(
  parameter N_CH = 8
) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Event system channels
  input wire [N_CH-1:0] ev_chan,
  // Serial peripheral frame commands
  input wire rx_count,
  input wire rx_restart,
  input wire tx_count,
  input wire tx_restart,
  // Clear requests from peripheral or event system, one per counter
  input wire [1:0] ext_clear,
  // Counter status
  output reg [1:0] update_evt_q,
  output reg [1:0] cmp_out_q,
  output reg [1:0] capture_flag_q
);
  // ****************************************
  // Configuration and counter state
  // ****************************************
  reg [2:0] cfg_mode_q;
  reg [3:0] clock_source_select_q;
  reg [3:0] wave_mode_q;
  reg [3:0] event_action_select_q;
  reg [2:0] event_channel_select_q;
  reg [15:0] count_value_q;
  reg [15:0] period_capture_reg_q;
  reg [15:0] compare_channel_a_q;
  reg [15:0] count_value_d;
  reg [15:0] period_capture_reg_d;
  reg [1:0] capture_flag_d;
  reg [1:0] cmp_out_d;
  reg [1:0] update_evt_d;
  reg [31:0] rd_data;

  // ****************************************
  // Bus decode
  // ****************************************
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite;
  wire hit_cfg = (paddr == `DBC_ADDR_CONFIG);
  wire hit_lane = (paddr == `DBC_ADDR_LANE);
  wire hit_cnt = (paddr == `DBC_ADDR_COUNT);
  wire hit_per = (paddr == `DBC_ADDR_PERIOD);
  wire hit_cmp = (paddr == `DBC_ADDR_COMPARE);
  wire hit_cmd = (paddr == `DBC_ADDR_COMMAND);
  wire hit_stat = (paddr == `DBC_ADDR_STATUS);
  wire mapped = hit_cfg | hit_lane | hit_cnt | hit_per | hit_cmp | hit_cmd | hit_stat;
  wire [1:0] sw_restart = (wr & hit_cmd) ? pwdata[`DBC_CMD_RESTART_LSB +: 2] : 2'b00;
  wire [1:0] sw_clear = (wr & hit_cmd) ? pwdata[`DBC_CMD_CLEAR_LSB +: 2] : 2'b00;
  wire [1:0] flag_clr = (wr & hit_stat) ? pwdata[1:0] : 2'b00;
  wire wide = (cfg_mode_q == `DBC_CFG_WIDE);

  always @*
  begin
    rd_data = `DBC_ZERO32;
    if (hit_cfg)
    begin
      rd_data[`DBC_CFG_MODE_LSB +: 3] = cfg_mode_q;
      rd_data[`DBC_CFG_CLK_LSB +: 4] = clock_source_select_q;
    end
    if (hit_lane)
    begin
      rd_data[`DBC_LANE_WAVE_LSB +: 2] = wave_mode_q[1:0];
      rd_data[`DBC_LANE_ACT_LSB +: 2] = event_action_select_q[1:0];
      rd_data[`DBC_LANE_STRIDE + `DBC_LANE_WAVE_LSB +: 2] = wave_mode_q[3:2];
      rd_data[`DBC_LANE_STRIDE + `DBC_LANE_ACT_LSB +: 2] = event_action_select_q[3:2];
      rd_data[`DBC_LANE_EVENT_CHANNEL_SELECT_LSB +: 3] = event_channel_select_q;
    end
    if (hit_cnt)
      rd_data[15:0] = count_value_q;
    if (hit_per)
      rd_data[15:0] = period_capture_reg_q;
    if (hit_cmp)
      rd_data[15:0] = compare_channel_a_q;
    if (hit_stat)
    begin
      rd_data[1:0] = capture_flag_q;
      rd_data[`DBC_STAT_CMP_LSB +: 2] = cmp_out_q;
      rd_data[`DBC_STAT_UPD_LSB +: 2] = update_evt_q;
    end
  end

  // ****************************************
  // Clock source and event edges
  // ****************************************
  wire clk_rise;
  wire tick;
  wire [1:0] cap_rise;
  wire [1:0] cap_fall;
  wire [2:0] ev_sel_b = event_channel_select_q + 3'h1;

  dbc_edge_pick #(.N_CH(N_CH), .SEL_W(3)) u_clk_edge (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ev_chan(ev_chan),
    .sel(clock_source_select_q[2:0]),
    .rise_q(clk_rise),
    .fall_q()
  );

  dbc_prescale u_presc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clock_source_select(clock_source_select_q),
    .ev_rise(clk_rise),
    .tick_q(tick)
  );

  dbc_edge_pick #(.N_CH(N_CH), .SEL_W(3)) u_cap_a (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ev_chan(ev_chan),
    .sel(event_channel_select_q),
    .rise_q(cap_rise[0]),
    .fall_q(cap_fall[0])
  );

  dbc_edge_pick #(.N_CH(N_CH), .SEL_W(3)) u_cap_b (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ev_chan(ev_chan),
    .sel(ev_sel_b),
    .rise_q(cap_rise[1]),
    .fall_q(cap_fall[1])
  );

  // ****************************************
  // Frame counter step
  // ****************************************
  function [7:0] pec_next;
    input [7:0] cur;
    input [7:0] plc;
    input cnt;
    input rst;
    begin
      if (rst | (cnt & (cur == 8'h00)))
        pec_next = plc;
      else if (cnt)
        pec_next = cur - 8'h01;
      else
        pec_next = cur;
    end
  endfunction

  // ****************************************
  // Per-lane next state
  // ****************************************
  integer i;
  integer cl;
  reg [7:0] cur;
  reg [7:0] top8;
  reg [7:0] rel8;
  reg [7:0] nc;
  reg [7:0] lo;
  reg [7:0] hi;
  reg [1:0] wm;
  reg [1:0] ac;
  reg bot;
  reg nxt_bot;
  reg tk;
  reg capture_mode;
  reg rst_ev;
  reg match;
  reg fr;

  always @*
  begin
    count_value_d = count_value_q;
    period_capture_reg_d = period_capture_reg_q;
    capture_flag_d = capture_flag_q & ~flag_clr;
    cmp_out_d = cmp_out_q;
    update_evt_d = 2'b00;
    cur = 8'h00;
    top8 = 8'h00;
    rel8 = 8'h00;
    nc = 8'h00;
    lo = 8'h00;
    hi = 8'h00;
    wm = 2'b00;
    ac = 2'b00;
    bot = 1'b0;
    nxt_bot = 1'b0;
    tk = 1'b0;
    capture_mode = 1'b0;
    rst_ev = 1'b0;
    match = 1'b0;
    fr = 1'b0;
    for (i = 0; i < 2; i = i + 1)
    begin
      cl = wide ? 0 : i;
      wm = wave_mode_q[2*cl +: 2];
      ac = event_action_select_q[2*cl +: 2];
      cur = count_value_q[8*i +: 8];
      top8 = (wm == `DBC_WAVE_CMP_TOP) ? compare_channel_a_q[8*i +: 8]
                                       : period_capture_reg_q[8*i +: 8];
      rel8 = (wm == `DBC_WAVE_CAPTURE) ? `DBC_MAX8 : top8;
      bot = wide ? (count_value_q == 16'h0000) : (cur == 8'h00);
      nxt_bot = wide ? (count_value_q == 16'h0001) : (cur == 8'h01);
      tk = (wide && i == 1) ? (tick && count_value_q[7:0] == 8'h00) : tick;
      match = wide ? (count_value_q == compare_channel_a_q)
                   : (cur == compare_channel_a_q[8*i +: 8]);
      capture_mode = (wm == `DBC_WAVE_CAPTURE) &&
             ((((ac == `DBC_ACT_INPUT) || (ac == `DBC_ACT_FREQUENCY_CAPTURE_ACTION)) && cap_rise[cl]) ||
              ((ac == `DBC_ACT_PULSE) && cap_fall[cl]));
      rst_ev = (wm == `DBC_WAVE_CAPTURE) && cap_rise[cl] &&
               ((ac == `DBC_ACT_FREQUENCY_CAPTURE_ACTION) || (ac == `DBC_ACT_PULSE));
      if (i == 0)
        fr = (cfg_mode_q == `DBC_CFG_TWO_FRAME);
      else
        fr = (cfg_mode_q == `DBC_CFG_BYTE_FRAME) || (cfg_mode_q == `DBC_CFG_TWO_FRAME) ||
             (cfg_mode_q == `DBC_CFG_BYTE_NIBBLE);
      nc = cur;
      if (fr)
      begin
        if ((i == 1) && (cfg_mode_q == `DBC_CFG_BYTE_NIBBLE))
        begin
          lo = pec_next({4'h0, cur[3:0]}, {4'h0, period_capture_reg_q[11:8]},
                        rx_count, rx_restart);
          hi = pec_next({4'h0, cur[7:4]}, {4'h0, period_capture_reg_q[15:12]},
                        tx_count, tx_restart);
          nc = {hi[3:0], lo[3:0]};
        end
        else if (i == 0)
          nc = pec_next(cur, period_capture_reg_q[7:0], rx_count, rx_restart);
        else
          nc = pec_next(cur, period_capture_reg_q[15:8], tx_count, tx_restart);
        if (sw_restart[i])
          nc = period_capture_reg_q[8*i +: 8];
      end
      else
      begin
        if (tk)
        begin
          if (bot)
          begin
            nc = rel8;
            cmp_out_d[i] = 1'b0;
            if (wm == `DBC_WAVE_CMP_TOP)
              update_evt_d[i] = 1'b1;
          end
          else
          begin
            nc = cur - 8'h01;
            if (match)
              cmp_out_d[i] = 1'b1;
            if (nxt_bot && wm != `DBC_WAVE_CMP_TOP)
              update_evt_d[i] = 1'b1;
          end
        end
        if (rst_ev || sw_restart[cl])
        begin
          nc = rel8;
          cmp_out_d[i] = 1'b0;
        end
        if (capture_mode)
        begin
          period_capture_reg_d[8*i +: 8] = cur;
          capture_flag_d[cl] = 1'b1;
        end
        else if (wr && hit_per && pstrb[i])
          period_capture_reg_d[8*i +: 8] = pwdata[8*i +: 8];
      end
      if (fr && wr && hit_per && pstrb[i])
        period_capture_reg_d[8*i +: 8] = pwdata[8*i +: 8];
      if (sw_clear[cl] || ext_clear[cl])
        nc = 8'h00;
      if (wr && hit_cnt && pstrb[i])
        nc = pwdata[8*i +: 8];
      count_value_d[8*i +: 8] = nc;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata <= `DBC_ZERO32;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cfg_mode_q <= `DBC_MODE_RST;
      clock_source_select_q <= `DBC_CLOCK_SOURCE_SELECT_RST;
      wave_mode_q <= 4'h0;
      event_action_select_q <= 4'h0;
      event_channel_select_q <= 3'h0;
      count_value_q <= `DBC_CNT_RST;
      period_capture_reg_q <= `DBC_PER_RST;
      compare_channel_a_q <= `DBC_CMP_RST;
      capture_flag_q <= 2'b00;
      cmp_out_q <= 2'b00;
      update_evt_q <= 2'b00;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= pwrite ? `DBC_ZERO32 : rd_data;
      if (wr && hit_cfg && pstrb[0])
      begin
        cfg_mode_q <= pwdata[`DBC_CFG_MODE_LSB +: 3];
        clock_source_select_q <= pwdata[`DBC_CFG_CLK_LSB +: 4];
      end
      if (wr && hit_lane)
      begin
        if (pstrb[0])
        begin
          wave_mode_q[1:0] <= pwdata[`DBC_LANE_WAVE_LSB +: 2];
          event_action_select_q[1:0] <= pwdata[`DBC_LANE_ACT_LSB +: 2];
        end
        if (pstrb[1])
        begin
          wave_mode_q[3:2] <= pwdata[`DBC_LANE_STRIDE + `DBC_LANE_WAVE_LSB +: 2];
          event_action_select_q[3:2] <= pwdata[`DBC_LANE_STRIDE + `DBC_LANE_ACT_LSB +: 2];
        end
        if (pstrb[2])
          event_channel_select_q <= pwdata[`DBC_LANE_EVENT_CHANNEL_SELECT_LSB +: 3];
      end
      if (wr && hit_cmp)
      begin
        if (pstrb[0])
          compare_channel_a_q[7:0] <= pwdata[7:0];
        if (pstrb[1])
          compare_channel_a_q[15:8] <= pwdata[15:8];
      end
      count_value_q <= count_value_d;
      period_capture_reg_q <= period_capture_reg_d;
      capture_flag_q <= capture_flag_d;
      cmp_out_q <= cmp_out_d;
      update_evt_q <= update_evt_d;
    end
  end
endmodule
`default_nettype wire

// ---- logic/dbc_map.vh ----
// Register map, field positions, codes and reset values of the dual byte counter
`ifndef DBC_MAP_VH
`define DBC_MAP_VH
// Byte addresses on the register bus
`define DBC_ADDR_CONFIG 8'h00
`define DBC_ADDR_LANE 8'h04
`define DBC_ADDR_COUNT 8'h08
`define DBC_ADDR_PERIOD 8'h0C
`define DBC_ADDR_COMPARE 8'h10
`define DBC_ADDR_COMMAND 8'h14
`define DBC_ADDR_STATUS 8'h18
// Field positions
`define DBC_CFG_MODE_LSB 0
`define DBC_CFG_CLK_LSB 4
`define DBC_LANE_WAVE_LSB 0
`define DBC_LANE_ACT_LSB 2
`define DBC_LANE_STRIDE 8
`define DBC_LANE_EVENT_CHANNEL_SELECT_LSB 16
`define DBC_CMD_RESTART_LSB 0
`define DBC_CMD_CLEAR_LSB 2
`define DBC_STAT_CMP_LSB 2
`define DBC_STAT_UPD_LSB 4
// Counter configurations
`define DBC_CFG_TWO_BYTE 3'h0
`define DBC_CFG_WIDE 3'h1
`define DBC_CFG_BYTE_FRAME 3'h2
`define DBC_CFG_TWO_FRAME 3'h3
`define DBC_CFG_BYTE_NIBBLE 3'h4
// Waveform modes
`define DBC_WAVE_NORMAL 2'h0
`define DBC_WAVE_CAPTURE 2'h1
`define DBC_WAVE_CMP_TOP 2'h2
// Event actions
`define DBC_ACT_OFF 2'h0
`define DBC_ACT_INPUT 2'h1
`define DBC_ACT_FREQUENCY_CAPTURE_ACTION 2'h2
`define DBC_ACT_PULSE 2'h3
// Clock selection codes
`define DBC_CLK_OFF 4'h0
`define DBC_CLK_DIV1 4'h1
`define DBC_CLK_DIV2 4'h2
`define DBC_CLK_DIV4 4'h3
`define DBC_CLK_DIV8 4'h4
`define DBC_CLK_DIV64 4'h5
`define DBC_CLK_DIV256 4'h6
`define DBC_CLK_DIV1024 4'h7
// Reset values and limits
`define DBC_MODE_RST 3'h0
`define DBC_CLOCK_SOURCE_SELECT_RST 4'h0
`define DBC_CNT_RST 16'h0000
`define DBC_PER_RST 16'hFFFF
`define DBC_CMP_RST 16'h0000
`define DBC_MAX8 8'hFF
`define DBC_ZERO32 32'h0000_0000
`define DBC_PRESC_W 10
`endif

// ---- logic/dbc_edge_pick.v ----
// Event channel picker with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none
module dbc_edge_pick #(
  parameter N_CH = 8,
  parameter SEL_W = 3
) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Channels and selection
  input wire [N_CH-1:0] ev_chan,
  input wire [SEL_W-1:0] sel,
  // Edge pulses
  output reg rise_q,
  output reg fall_q
);
  reg [N_CH-1:0] prev_q;

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prev_q <= {N_CH{1'b0}};
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      prev_q <= ev_chan;
      rise_q <= ev_chan[sel] & ~prev_q[sel];
      fall_q <= ~ev_chan[sel] & prev_q[sel];
    end
  end
endmodule
`default_nettype wire

// ---- logic/dbc_prescale.v ----
// Common prescaler and clock source selection for both counters
`timescale 1ns/1ps
`default_nettype none
`include "dbc_map.vh"
module dbc_prescale #(
  parameter PW = `DBC_PRESC_W
) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Selection and event clock
  input wire [3:0] clock_source_select,
  input wire ev_rise,
  // Count enable pulse
  output reg tick_q
);
  reg [PW-1:0] div_q;
  reg sel_tick;

  always @*
  begin
    case (clock_source_select)
      `DBC_CLK_OFF: sel_tick = 1'b0;
      `DBC_CLK_DIV1: sel_tick = 1'b1;
      `DBC_CLK_DIV2: sel_tick = &div_q[0:0];
      `DBC_CLK_DIV4: sel_tick = &div_q[1:0];
      `DBC_CLK_DIV8: sel_tick = &div_q[2:0];
      `DBC_CLK_DIV64: sel_tick = &div_q[5:0];
      `DBC_CLK_DIV256: sel_tick = &div_q[7:0];
      `DBC_CLK_DIV1024: sel_tick = &div_q[9:0];
      default: sel_tick = ev_rise;
    endcase
  end

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_q <= {PW{1'b0}};
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_q + {{(PW-1){1'b0}}, 1'b1};
      tick_q <= sel_tick;
    end
  end
endmodule
`default_nettype wire

// ---- dv/dbc_ev_model.sv ----
// Event system model: clean channel edges on request
`timescale 1ns/1ps
`default_nettype none
module dbc_ev_model #(
  parameter N_CH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Requests
  input wire logic go,
  input wire logic [2:0] ch,
  // Channels
  output logic [N_CH-1:0] ev_chan,
  output logic busy
);
  logic [2:0] sel_q;
  logic [2:0] step_q;
  // One pulse: high three cycles, low four; single clean edges
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      sel_q <= 3'h0;
      step_q <= 3'h0;
    end
    else if (step_q != 3'h0)
      step_q <= step_q + 3'h1;
    else if (go)
    begin
      sel_q <= ch;
      step_q <= 3'h1;
    end
  assign ev_chan = (step_q != 3'h0 && step_q < 3'h4) ? ({{(N_CH-1){1'b0}}, 1'b1} << sel_q) : '0;
  assign busy = (step_q != 3'h0);
endmodule
`default_nettype wire

// ---- dv/dbc_checker.sv ----
// Port checks for the dual byte counter
`timescale 1ns/1ps
`default_nettype none
`include "dbc_map.vh"
module dbc_checker #(
  parameter N_CH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Events and status
  input wire logic [N_CH-1:0] ev_chan,
  input wire logic [1:0] update_evt_q,
  input wire logic [1:0] cmp_out_q,
  input wire logic [1:0] capture_flag_q
);
  logic done_w;
  logic [1:0] clr_w;
  logic cfg_seen_q;
  logic [N_CH-1:0] ev_q;
  logic [3:0] quiet_q;
  assign done_w = psel & penable & pready & pwrite;
  assign clr_w = {2{done_w && paddr == `DBC_ADDR_STATUS}} & pwdata[1:0];
  // Config write seen, cycles since last channel change
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      cfg_seen_q <= 1'b0;
      ev_q <= '0;
      quiet_q <= 4'hF;
    end
    else
    begin
      ev_q <= ev_chan;
      if (done_w && paddr == `DBC_ADDR_CONFIG)
        cfg_seen_q <= 1'b1;
      if (ev_chan != ev_q)
        quiet_q <= 4'h0;
      else if (quiet_q != 4'hF)
        quiet_q <= quiet_q + 4'h1;
    end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  a_idle_after_reset:
  assert property (!cfg_seen_q |-> update_evt_q == 2'b00 && capture_flag_q == 2'b00)
    else $error("counter active before configuration");
  a_capture_a_cause:
  assert property ($rose(capture_flag_q[0]) |-> quiet_q <= 4'h4)
    else $error("capture flag a without channel edge");
  a_capture_b_cause:
  assert property ($rose(capture_flag_q[1]) |-> quiet_q <= 4'h4)
    else $error("capture flag b without channel edge");
  a_flag_a_sticky:
  assert property ($fell(capture_flag_q[0]) |-> $past(clr_w[0]))
    else $error("capture flag a dropped without clear");
  a_flag_b_sticky:
  assert property ($fell(capture_flag_q[1]) |-> $past(clr_w[1]))
    else $error("capture flag b dropped without clear");
  a_restart_cmp_low:
  assert property (done_w && paddr == `DBC_ADDR_COMMAND && pwdata[0] |=> !cmp_out_q[0])
    else $error("compare output not zero after restart");
  a_ready_one_cycle:
  assert property (pready |=> !pready)
    else $error("ready held over two cycles");
  a_setup_answered:
  assert property (psel && !penable |=> pready)
    else $error("setup not answered next cycle");
  c_capture: cover property ($rose(capture_flag_q[0]));
  c_update: cover property (update_evt_q[0]);
  c_restart: cover property (done_w && paddr == `DBC_ADDR_COMMAND);
endmodule
bind dbc_top dbc_checker #(.N_CH(N_CH)) u_dbc_checker (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .ev_chan(ev_chan),
  .update_evt_q(update_evt_q), .cmp_out_q(cmp_out_q), .capture_flag_q(capture_flag_q)
);
`default_nettype wire

// ---- dv/tb.sv ----
// Directed testbench for the dual byte counter
`timescale 1ns/1ps
`default_nettype none
`include "dbc_map.vh"
module tb;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, ev_go, ev_busy, rerr;
  logic [7:0] paddr, ev_chan;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic [2:0] ev_ch;
  logic [1:0] ext_clear, update_evt_q, cmp_out_q, capture_flag_q;
  logic rx_count, rx_restart, tx_count, tx_restart;
  int n_errors, n_compared, n_upd_a, n_upd_b;
  dbc_top #(.N_CH(8)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ev_chan(ev_chan),
    .rx_count(rx_count), .rx_restart(rx_restart),
    .tx_count(tx_count), .tx_restart(tx_restart),
    .ext_clear(ext_clear), .update_evt_q(update_evt_q), .cmp_out_q(cmp_out_q),
    .capture_flag_q(capture_flag_q));
  dbc_ev_model #(.N_CH(8)) u_ev (.core_clk(core_clk), .sys_rst(sys_rst), .go(ev_go),
    .ch(ev_ch), .ev_chan(ev_chan), .busy(ev_busy));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    n_upd_a <= n_upd_a + int'(update_evt_q[0] === 1'b1);
    n_upd_b <= n_upd_b + int'(update_evt_q[1] === 1'b1);
  end
  task report_and_stop;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task give_up;
    n_errors++;
    report_and_stop;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      give_up;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rdat & m, exp);
  endtask
  task frm(input logic [3:0] v);
    {tx_restart, tx_count, rx_restart, rx_count} <= v;
    @(posedge core_clk);
    {tx_restart, tx_count, rx_restart, rx_count} <= 4'h0;
    @(posedge core_clk);
  endtask
  task pulse(input logic [2:0] c, input int n);
    int k;
    repeat (n)
    begin
      ev_ch <= c;
      ev_go <= 1'b1;
      @(posedge core_clk);
      ev_go <= 1'b0;
      k = 0;
      do
      begin
        @(posedge core_clk);
        k++;
      end
      while (ev_busy === 1'b1 && k < 20);
      if (k >= 20)
        give_up;
    end
  endtask
  initial
  begin
    {n_errors, n_compared, n_upd_a, n_upd_b} = '0;
    {sys_rst, psel, penable, pwrite, ev_go} = 5'b1_0000;
    {paddr, pwdata, pstrb, ev_ch, ext_clear, rx_count, rx_restart, tx_count, tx_restart} = '0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    // Reset values, stopped counter, unmapped address
    rd(`DBC_ADDR_CONFIG, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(`DBC_ADDR_LANE, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(`DBC_ADDR_PERIOD, 32'hFFFF_FFFF, 32'h0000_FFFF);
    rd(`DBC_ADDR_COMPARE, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(`DBC_ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    repeat (20) @(posedge core_clk);
    rd(`DBC_ADDR_COUNT, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
    $display("reset test done");
    // Two byte counters on channel 0 edges
    apb(1'b1, `DBC_ADDR_CONFIG, 32'h0000_0080, 4'hF);
    apb(1'b1, `DBC_ADDR_COUNT, 32'h0000_0302, 4'h3);
    apb(1'b1, `DBC_ADDR_PERIOD, 32'h0000_0504, 4'h3);
    pulse(3'h0, 3);
    rd(`DBC_ADDR_COUNT, 32'h0000_FFFF, 32'h0000_0004);
    apb(1'b1, `DBC_ADDR_PERIOD, 32'h0000_0907, 4'h3);
    pulse(3'h0, 1);
    rd(`DBC_ADDR_COUNT, 32'h0000_FFFF, 32'h0000_0903);
    pulse(3'h0, 3);
    rd(`DBC_ADDR_COUNT, 32'h0000_FFFF, 32'h0000_0600);
    pulse(3'h0, 1);
    rd(`DBC_ADDR_COUNT, 32'h0000_FFFF, 32'h0000_0507);
    chk(n_upd_a, 32'h0000_0002);
    chk(n_upd_b, 32'h0000_0001);
    pulse(3'h0, 1);
    apb(1'b1, `DBC_ADDR_COMMAND, 32'h0000_0001, 4'hF);
    rd(`DBC_ADDR_COUNT, 32'h0000_FFFF, 32'h0000_0407);
    ext_clear <= 2'b10;
    repeat (2) @(posedge core_clk);
    ext_clear <= 2'b00;
    @(posedge core_clk);
    rd(`DBC_ADDR_COUNT, 32'h0000_FFFF, 32'h0000_0007);
    $display("normal test done");
    // Input capture on channel 1, clear, reload with all ones
    apb(1'b1, `DBC_ADDR_LANE, 32'h0001_0005, 4'h5);
    apb(1'b1, `DBC_ADDR_COUNT, 32'h0000_0010, 4'h1);
    pulse(3'h0, 2);
    pulse(3'h1, 1);
    rd(`DBC_ADDR_PERIOD, 32'h0000_00FF, 32'h0000_000E);
    rd(`DBC_ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    apb(1'b1, `DBC_ADDR_STATUS, 32'h0000_0001, 4'h1);
    rd(`DBC_ADDR_STATUS, 32'h0000_0001, 32'h0000_0000);
    apb(1'b1, `DBC_ADDR_COUNT, 32'h0000_0001, 4'h1);
    pulse(3'h0, 2);
    rd(`DBC_ADDR_COUNT, 32'h0000_00FF, 32'h0000_00FF);
    pulse(3'h1, 1);
    rd(`DBC_ADDR_PERIOD, 32'h0000_00FF, 32'h0000_00FF);
    $display("capture test done");
    // Frequency capture restarts the counter
    apb(1'b1, `DBC_ADDR_LANE, 32'h0001_0009, 4'h5);
    apb(1'b1, `DBC_ADDR_COUNT, 32'h0000_0020, 4'h1);
    pulse(3'h1, 1);
    rd(`DBC_ADDR_PERIOD, 32'h0000_00FF, 32'h0000_0020);
    rd(`DBC_ADDR_COUNT, 32'h0000_00FF, 32'h0000_00FF);
    $display("frequency test done");
    // Cascaded wide counter with capture
    apb(1'b1, `DBC_ADDR_CONFIG, 32'h0000_0081, 4'hF);
    apb(1'b1, `DBC_ADDR_LANE, 32'h0001_0005, 4'h5);
    apb(1'b1, `DBC_ADDR_COUNT, 32'h0000_0100, 4'h3);
    pulse(3'h0, 1);
    rd(`DBC_ADDR_COUNT, 32'h0000_FFFF, 32'h0000_00FF);
    pulse(3'h1, 1);
    rd(`DBC_ADDR_PERIOD, 32'h0000_FFFF, 32'h0000_00FF);
    apb(1'b1, `DBC_ADDR_COUNT, 32'h0000_0001, 4'h3);
    pulse(3'h0, 2);
    rd(`DBC_ADDR_COUNT, 32'h0000_FFFF, 32'h0000_FFFF);
    $display("wide test done");
    // Compare output, second lane capture on the next channel, pulse width
    apb(1'b1, `DBC_ADDR_CONFIG, 32'h0000_0080, 4'hF);
    apb(1'b1, `DBC_ADDR_LANE, 32'h0002_0500, 4'h7);
    apb(1'b1, `DBC_ADDR_COMPARE, 32'h0000_0003, 4'h3);
    apb(1'b1, `DBC_ADDR_COUNT, 32'h0000_1005, 4'h3);
    pulse(3'h0, 3);
    chk(cmp_out_q, 32'h0000_0001);
    rd(`DBC_ADDR_STATUS, 32'h0000_000C, 32'h0000_0004);
    pulse(3'h3, 1);
    rd(`DBC_ADDR_PERIOD, 32'h0000_FF00, 32'h0000_0D00);
    chk(capture_flag_q, 32'h0000_0003);
    apb(1'b1, `DBC_ADDR_STATUS, 32'h0000_0002, 4'h1);
    chk(capture_flag_q, 32'h0000_0001);
    apb(1'b1, `DBC_ADDR_COMMAND, 32'h0000_0001, 4'hF);
    chk(cmp_out_q, 32'h0000_0000);
    apb(1'b1, `DBC_ADDR_LANE, 32'h0001_000D, 4'h5);
    apb(1'b1, `DBC_ADDR_PERIOD, 32'h0000_0030, 4'h1);
    apb(1'b1, `DBC_ADDR_COUNT, 32'h0000_0040, 4'h1);
    pulse(3'h1, 1);
    rd(`DBC_ADDR_PERIOD, 32'h0000_00FF, 32'h0000_00FF);
    rd(`DBC_ADDR_COUNT, 32'h0000_00FF, 32'h0000_00FF);
    $display("compare and pulse width test done");
    // Two nibble frame counters on lane B
    apb(1'b1, `DBC_ADDR_CONFIG, 32'h0000_0004, 4'hF);
    apb(1'b1, `DBC_ADDR_PERIOD, 32'h0000_2100, 4'h2);
    apb(1'b1, `DBC_ADDR_COUNT, 32'h0000_0000, 4'h2);
    frm(4'h5);
    frm(4'h1);
    frm(4'h6);
    frm(4'h8);
    rd(`DBC_ADDR_COUNT, 32'h0000_FF00, 32'h0000_2100);
    $display("frame test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
